// >>> sge_pkg.sv
// sge_pkg: shared constants, register map and carrier types of the spi gpio expander.
// assumes: included before any sge module; no tool-specific settings.
package sge_pkg;
  localparam int SGE_LINES = 16;
  // spi frame: cmd byte = {rd_wr, addr[6:0]}, then one data byte, msb first, mode 0
  localparam int SGE_CMD_BITS = 8;
  localparam int SGE_FRAME_BITS = 16;
  localparam int SGE_CNT_W = 5;
  localparam logic [SGE_CNT_W-1:0] SGE_CNT_CMD_DONE = 5'h08;
  localparam logic [SGE_CNT_W-1:0] SGE_CNT_FRAME_DONE = 5'h10;
  localparam int SGE_RW_BIT = 7;
  localparam int SGE_ADDR_W = 7;
  // register indices; each holds eight lines, low byte then high byte
  localparam logic [3:0] SGE_REG_INPUT_LO = 4'h0;
  localparam logic [3:0] SGE_REG_INPUT_HI = 4'h1;
  localparam logic [3:0] SGE_REG_OUT_LO = 4'h2;
  localparam logic [3:0] SGE_REG_OUT_HI = 4'h3;
  localparam logic [3:0] SGE_REG_INV_LO = 4'h4;
  localparam logic [3:0] SGE_REG_INV_HI = 4'h5;
  localparam logic [3:0] SGE_REG_DIR_LO = 4'h6;
  localparam logic [3:0] SGE_REG_DIR_HI = 4'h7;
  localparam logic [3:0] SGE_REG_PULL_LO = 4'h8;
  localparam logic [3:0] SGE_REG_PULL_HI = 4'h9;
  localparam logic [3:0] SGE_REG_TRI_LO = 4'ha;
  localparam logic [3:0] SGE_REG_TRI_HI = 4'hb;
  localparam logic [3:0] SGE_REG_IEN_LO = 4'hc;
  localparam logic [3:0] SGE_REG_IEN_HI = 4'hd;
  localparam logic [3:0] SGE_REG_RISE_LO = 4'he;
  localparam logic [3:0] SGE_REG_RISE_HI = 4'hf;
  localparam logic [SGE_ADDR_W-1:0] SGE_REG_FALL_LO = 7'h10;
  localparam logic [SGE_ADDR_W-1:0] SGE_REG_FALL_HI = 7'h11;
  localparam logic [SGE_ADDR_W-1:0] SGE_REG_PEND_LO = 7'h12;
  localparam logic [SGE_ADDR_W-1:0] SGE_REG_PEND_HI = 7'h13;
  localparam int SGE_NUM_REGS = 20;
  localparam logic [15:0] SGE_RST_ZERO = 16'h0000;
  localparam logic [15:0] SGE_RST_ONES = 16'hffff;
  // reset pulse and spi rate limits
  localparam real SGE_RST_MIN_NS = 40.0;
  localparam real SGE_CLK_NS = 4.0;
  localparam int SGE_RST_MIN_CYC = int'($ceil(SGE_RST_MIN_NS / SGE_CLK_NS));
  localparam real SGE_SPI_MAX_MHZ = 26.0;

  typedef struct packed {
    logic [15:0] out_level;
    logic [15:0] invert;
    logic [15:0] dir_in;
    logic [15:0] pull_en;
    logic [15:0] tri_en;
    logic [15:0] int_en;
    logic [15:0] rise_en;
    logic [15:0] fall_en;
  } sge_cfg_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } sge_spi_in_t;

  typedef enum logic [1:0] {SGE_IDLE, SGE_CMD, SGE_DATA, SGE_DONE} sge_phase_t;
endpackage : sge_pkg

// >>> sge_regfile.sv
// sge_regfile: per-line configuration storage with registered read data.
// assumes: write strobe and address come from logic on clk.
`timescale 1ns/10ps
`default_nettype none
module sge_regfile
  import sge_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [SGE_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [15:0] input_state,
  input wire logic [15:0] pending,
  output var logic [7:0] rdata,
  output var sge_cfg_t cfg
);
  typedef struct packed {
    sge_cfg_t cfg;
    logic [7:0] rdata;
  } sge_rf_state_t;

  sge_rf_state_t st_reg;
  sge_rf_state_t st_next;

  function automatic logic [7:0] sge_pick(input logic [15:0] v, input logic hi);
    return hi ? v[15:8] : v[7:0];
  endfunction : sge_pick

  function automatic logic [15:0] sge_put(input logic [15:0] v, input logic hi, input logic [7:0] b);
    return hi ? {b, v[7:0]} : {v[15:8], b};
  endfunction : sge_put

  always_comb begin
    logic hi;
    hi = addr[0];
    st_next = st_reg;
    unique case (addr[SGE_ADDR_W-1:1])
      6'(SGE_REG_INPUT_LO >> 1): st_next.rdata = sge_pick(input_state, hi);
      6'(SGE_REG_OUT_LO >> 1): st_next.rdata = sge_pick(st_reg.cfg.out_level, hi);
      6'(SGE_REG_INV_LO >> 1): st_next.rdata = sge_pick(st_reg.cfg.invert, hi);
      6'(SGE_REG_DIR_LO >> 1): st_next.rdata = sge_pick(st_reg.cfg.dir_in, hi);
      6'(SGE_REG_PULL_LO >> 1): st_next.rdata = sge_pick(st_reg.cfg.pull_en, hi);
      6'(SGE_REG_TRI_LO >> 1): st_next.rdata = sge_pick(st_reg.cfg.tri_en, hi);
      6'(SGE_REG_IEN_LO >> 1): st_next.rdata = sge_pick(st_reg.cfg.int_en, hi);
      6'(SGE_REG_RISE_LO >> 1): st_next.rdata = sge_pick(st_reg.cfg.rise_en, hi);
      6'(SGE_REG_FALL_LO >> 1): st_next.rdata = sge_pick(st_reg.cfg.fall_en, hi);
      6'(SGE_REG_PEND_LO >> 1): st_next.rdata = sge_pick(pending, hi);
      default: st_next.rdata = 8'h00;
    endcase
    if (wr_en) begin
      unique case (addr[SGE_ADDR_W-1:1])
        6'(SGE_REG_OUT_LO >> 1): st_next.cfg.out_level = sge_put(st_reg.cfg.out_level, hi, wdata);
        6'(SGE_REG_INV_LO >> 1): st_next.cfg.invert = sge_put(st_reg.cfg.invert, hi, wdata);
        6'(SGE_REG_DIR_LO >> 1): st_next.cfg.dir_in = sge_put(st_reg.cfg.dir_in, hi, wdata);
        6'(SGE_REG_PULL_LO >> 1): st_next.cfg.pull_en = sge_put(st_reg.cfg.pull_en, hi, wdata);
        6'(SGE_REG_TRI_LO >> 1): st_next.cfg.tri_en = sge_put(st_reg.cfg.tri_en, hi, wdata);
        6'(SGE_REG_IEN_LO >> 1): st_next.cfg.int_en = sge_put(st_reg.cfg.int_en, hi, wdata);
        6'(SGE_REG_RISE_LO >> 1): st_next.cfg.rise_en = sge_put(st_reg.cfg.rise_en, hi, wdata);
        6'(SGE_REG_FALL_LO >> 1): st_next.cfg.fall_en = sge_put(st_reg.cfg.fall_en, hi, wdata);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg.cfg.out_level <= SGE_RST_ZERO;
      st_reg.cfg.invert <= SGE_RST_ZERO;
      st_reg.cfg.dir_in <= SGE_RST_ONES;
      st_reg.cfg.pull_en <= SGE_RST_ZERO;
      st_reg.cfg.tri_en <= SGE_RST_ZERO;
      st_reg.cfg.int_en <= SGE_RST_ZERO;
      st_reg.cfg.rise_en <= SGE_RST_ZERO;
      st_reg.cfg.fall_en <= SGE_RST_ZERO;
      st_reg.rdata <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign cfg = st_reg.cfg;
endmodule : sge_regfile
`default_nettype wire

// >>> sge_top.sv
// sge_top: sixteen-line gpio expander behind an spi slave, sclk oversampled by clk.
// assumes: clk well above 2x sclk; spi mode 0, msb first; pins resolved by the bench.
// Operation
// - sixteen lines, each set individually over an spi slave port
// - output lines drive high, low, or float per line
// - each input has its own software-switchable pull-up
// - each input's sensed level may be inverted before reporting
// - per-line interrupt enable on rising, falling or both edges
// - pending interrupt clears when input returns, or host reads input state
// - open-drain interrupt pin pulls low while any interrupt pending
// - reset low over 40 ns clears registers, all lines inputs; host holds it
// - spi slave: sclk, cs, data in from host, drives data out, max 26 MHz
`timescale 1ns/10ps
`default_nettype none
module sge_top
  import sge_pkg::*;
#(
  parameter int LINES = SGE_LINES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  input wire logic [LINES-1:0] gpio_in,
  output logic [LINES-1:0] gpio_out,
  output logic [LINES-1:0] gpio_oe_n,
  output logic [LINES-1:0] gpio_pull_en,
  output logic irq_out,
  output logic irq_oe_n
);
  typedef struct packed {
    sge_spi_in_t sync1;
    sge_spi_in_t sync2;
    logic sclk_d;
    logic [LINES-1:0] pin_s1;
    logic [LINES-1:0] pin_s2;
    logic [LINES-1:0] ref_lvl;
    logic [LINES-1:0] lvl_d;
    logic [LINES-1:0] pend;
    sge_phase_t phase;
    logic [SGE_CNT_W-1:0] bitcnt;
    logic [SGE_CMD_BITS-1:0] shift;
    logic rd;
    logic [SGE_ADDR_W-1:0] addr;
    logic [SGE_CMD_BITS-1:0] tx;
    logic wr_pulse;
    logic miso;
    logic miso_oe_n;
    logic [LINES-1:0] out;
    logic [LINES-1:0] oe_n;
    logic [LINES-1:0] pull;
    logic irq_oe_n;
    logic irq_dat;
  } sge_state_t;

  sge_state_t st_reg;
  sge_state_t st_next;
  sge_cfg_t cfg;
  logic [7:0] rf_rdata;
  logic [LINES-1:0] level;
  logic input_read;

  // per-line edge test against the level of the cycle before
  function automatic logic [LINES-1:0] sge_edges(
    input logic [LINES-1:0] now,
    input logic [LINES-1:0] was,
    input logic [LINES-1:0] rise_en,
    input logic [LINES-1:0] fall_en
  );
    return (now & ~was & rise_en) | (~now & was & fall_en);
  endfunction : sge_edges

  // both input bytes share one index pair
  function automatic logic sge_is_input_reg(input logic [SGE_ADDR_W-1:0] a);
    return a[SGE_ADDR_W-1:1] == 6'(SGE_REG_INPUT_LO >> 1);
  endfunction : sge_is_input_reg

  assign level = st_reg.pin_s2 ^ cfg.invert[LINES-1:0];
  // a read of either input byte counts as reading the input state
  assign input_read = st_reg.rd && (st_reg.phase == SGE_DATA) && (st_reg.bitcnt == SGE_CNT_CMD_DONE)
    && sge_is_input_reg(st_reg.addr);

  sge_regfile u_regfile (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(st_reg.wr_pulse),
    .addr(st_reg.addr),
    .wdata(st_reg.shift),
    .input_state(16'(level)),
    .pending(16'(st_reg.pend)),
    .rdata(rf_rdata),
    .cfg(cfg)
  );

  always_comb begin
    logic rise;
    logic fall;
    logic load_now;
    logic [LINES-1:0] edge_hit;
    logic [LINES-1:0] arm;
    rise = 1'b0;
    fall = 1'b0;
    load_now = 1'b0;
    edge_hit = '0;
    arm = '0;
    st_next = st_reg;
    st_next.sync1 = '{sclk: spi_sclk, cs_n: spi_cs_n, mosi: spi_mosi};
    st_next.sync2 = st_reg.sync1;
    st_next.sclk_d = st_reg.sync2.sclk;
    st_next.pin_s1 = gpio_in;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.wr_pulse = 1'b0;
    rise = st_reg.sync2.sclk && !st_reg.sclk_d;
    fall = !st_reg.sync2.sclk && st_reg.sclk_d;
    load_now = st_reg.rd && (st_reg.phase == SGE_DATA) && (st_reg.bitcnt == SGE_CNT_CMD_DONE);

    // spi slave framing
    if (st_reg.sync2.cs_n) begin
      st_next.phase = SGE_IDLE;
      st_next.bitcnt = '0;
      st_next.miso_oe_n = 1'b1;
    end else begin
      st_next.miso_oe_n = 1'b0;
      if (st_reg.phase == SGE_IDLE) begin
        st_next.phase = SGE_CMD;
      end
      if (rise && st_reg.phase != SGE_DONE) begin
        st_next.shift = {st_reg.shift[SGE_CMD_BITS-2:0], st_reg.sync2.mosi};
        st_next.bitcnt = st_reg.bitcnt + 1'b1;
        if (st_reg.bitcnt == SGE_CNT_CMD_DONE - 1'b1) begin
          st_next.rd = st_reg.shift[SGE_RW_BIT-1];
          st_next.addr = {st_reg.shift[SGE_ADDR_W-2:0], st_reg.sync2.mosi};
          st_next.phase = SGE_DATA;
        end
        if (st_reg.bitcnt == SGE_CNT_FRAME_DONE - 1'b1) begin
          st_next.phase = SGE_DONE;
          st_next.wr_pulse = !st_reg.rd;
        end
      end
      // the 8th fall puts the msb out so that the host's 9th rise samples it;
      // limitation: sclk high must last at least 2 clk for the read word to settle
      if (fall && load_now) begin
        st_next.miso = rf_rdata[SGE_CMD_BITS-1];
        st_next.tx = {rf_rdata[SGE_CMD_BITS-2:0], 1'b0};
      end else if (fall) begin
        st_next.miso = st_reg.tx[SGE_CMD_BITS-1];
        st_next.tx = {st_reg.tx[SGE_CMD_BITS-2:0], 1'b0};
      end
    end

    // pending keeps the level from before the edge, so a return to it clears
    st_next.lvl_d = level;
    arm = cfg.int_en[LINES-1:0] & cfg.dir_in[LINES-1:0];
    edge_hit = arm & sge_edges(level, st_reg.lvl_d, cfg.rise_en[LINES-1:0], cfg.fall_en[LINES-1:0]);
    for (int i = 0; i < LINES; i++) begin
      if (edge_hit[i]) begin
        // set wins over a return or a read in the same cycle
        st_next.pend[i] = 1'b1;
        if (!st_reg.pend[i]) begin
          st_next.ref_lvl[i] = st_reg.lvl_d[i];
        end
      end else if (st_reg.pend[i] && arm[i] && (level[i] == st_reg.ref_lvl[i] || input_read)) begin
        st_next.pend[i] = 1'b0;
        st_next.ref_lvl[i] = level[i];
      end else if (!st_reg.pend[i] || !arm[i]) begin
        st_next.pend[i] = 1'b0;
        st_next.ref_lvl[i] = level[i];
      end
    end
    st_next.irq_oe_n = ~|st_next.pend;
    // open-drain data is always low; only the enable moves
    st_next.irq_dat = 1'b0;

    // pad drive; oe_n low while driving
    st_next.out = cfg.out_level[LINES-1:0];
    st_next.oe_n = cfg.dir_in[LINES-1:0] | cfg.tri_en[LINES-1:0];
    st_next.pull = cfg.pull_en[LINES-1:0] & cfg.dir_in[LINES-1:0];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // sync flops start at idle pin levels: no false sclk edge or frame after reset
      st_reg.sync1 <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      st_reg.sync2 <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      st_reg.sclk_d <= 1'b0;
      st_reg.pin_s1 <= '0;
      st_reg.pin_s2 <= '0;
      st_reg.ref_lvl <= '0;
      st_reg.lvl_d <= '0;
      st_reg.pend <= '0;
      st_reg.phase <= SGE_IDLE;
      st_reg.bitcnt <= '0;
      st_reg.shift <= '0;
      st_reg.rd <= 1'b0;
      st_reg.addr <= '0;
      st_reg.tx <= '0;
      st_reg.wr_pulse <= 1'b0;
      st_reg.miso <= 1'b0;
      st_reg.miso_oe_n <= 1'b1;
      st_reg.out <= '0;
      st_reg.oe_n <= '1;
      st_reg.pull <= '0;
      st_reg.irq_oe_n <= 1'b1;
      st_reg.irq_dat <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign spi_miso = st_reg.miso;
  assign spi_miso_oe_n = st_reg.miso_oe_n;
  assign gpio_out = st_reg.out;
  assign gpio_oe_n = st_reg.oe_n;
  assign gpio_pull_en = st_reg.pull;
  assign irq_out = st_reg.irq_dat;
  assign irq_oe_n = st_reg.irq_oe_n;
endmodule : sge_top
`default_nettype wire

// >>> sge_spi_host.sv
// sge_spi_host: spi mode 0 host model, one 16-bit frame per call.
// assumes: clk at 250 MHz; sclk low outside frames.
`timescale 1ns/10ps
`default_nettype none
module sge_spi_host (
  input wire logic clk,
  input wire logic miso,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end
  // 40 ns period, not 32: keeps the link under 26 MHz
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    @(negedge clk) cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = tx[i];
      repeat (5) @(negedge clk);
      sclk = 1'b1;
      if (i < 8) rx[i] = miso;
      repeat (5) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (5) @(negedge clk);
    cs_n = 1'b1;
    // released line shows the inverse, never a stale level
    mosi = ~mosi;
    repeat (6) @(negedge clk);
  endtask : xfer
endmodule : sge_spi_host
`default_nettype wire

// >>> sge_top_assertions.sv
// sge_top_assertions: port-level checks of sge_top.
// assumes: one clk domain; bound into every sge_top.
`timescale 1ns/10ps
`default_nettype none
module sge_top_assertions
  import sge_pkg::*;
#(
  parameter int LINES = SGE_LINES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe_n,
  input wire logic [LINES-1:0] gpio_in,
  input wire logic [LINES-1:0] gpio_out,
  input wire logic [LINES-1:0] gpio_oe_n,
  input wire logic [LINES-1:0] gpio_pull_en,
  input wire logic irq_out,
  input wire logic irq_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [LINES-1:0] prev_in_reg;
  logic [3:0] quiet_reg;
  // cycles since a pad changed, saturating
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_in_reg <= '0;
      quiet_reg <= 4'hf;
    end else begin
      prev_in_reg <= gpio_in;
      if (gpio_in != prev_in_reg) quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hf) quiet_reg <= quiet_reg + 4'h1;
    end
  end
  sequence s_cs_high; spi_cs_n [*4]; endsequence
  sequence s_cs_low; !spi_cs_n [*4]; endsequence
  sequence s_idle; spi_cs_n [*8]; endsequence
  property p_irq_data; irq_out == 1'b0; endproperty
  property p_irq_cause; $fell(irq_oe_n) |-> quiet_reg < 4'hb; endproperty
  property p_cs_off; s_cs_high |-> spi_miso_oe_n; endproperty
  property p_cs_on; s_cs_low |-> !spi_miso_oe_n; endproperty
  property p_pull; (gpio_pull_en & ~gpio_oe_n) == '0; endproperty
  property p_rst_vals;
    disable iff (1'b0) !reset_n |-> &gpio_oe_n && irq_oe_n && spi_miso_oe_n && gpio_out == '0 && gpio_pull_en == '0;
  endproperty
  property p_rst_rel; $rose(reset_n) |-> (&gpio_oe_n) [*3]; endproperty
  property p_idle; s_idle |=> $stable(gpio_out) && $stable(gpio_oe_n) && $stable(gpio_pull_en); endproperty
  a_irq_data: assert property (p_irq_data) else $error("irq data not low");
  a_irq_cause: assert property (p_irq_cause) else $error("irq without input edge");
  a_cs_off: assert property (p_cs_off) else $error("miso driven while idle");
  a_cs_on: assert property (p_cs_on) else $error("miso not driven in frame");
  a_pull: assert property (p_pull) else $error("pull on driven line");
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  a_rst_rel: assert property (p_rst_rel) else $error("line not input after reset");
  a_idle: assert property (p_idle) else $error("pins changed while idle");
endmodule : sge_top_assertions
bind sge_top sge_top_assertions #(.LINES(LINES)) i_sge_chk (.clk(clk), .reset_n(reset_n),
  .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
  .spi_miso_oe_n(spi_miso_oe_n), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
  .gpio_pull_en(gpio_pull_en), .irq_out(irq_out), .irq_oe_n(irq_oe_n));
`default_nettype wire

// >>> sge_top_bench.sv
// sge_top_bench: self-checking bench of sge_top with an spi host model.
// assumes: sge_pkg, sge_top, sge_spi_host and checker compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; $display("FAIL %0t mismatch", $time); end end
module sge_top_bench import sge_pkg::*;;
  logic clk = 1'b1;
  logic reset_n = 1'b1;
  logic [15:0] ext_val = 16'h0000;
  int mismatches = 0;
  int comparisons = 0;
  wire logic sclk, cs_n, mosi, miso, miso_oe_n, miso_w, irq_out, irq_oe_n, irq_n;
  wire logic [15:0] pad, gpio_out, gpio_oe_n, gpio_pull_en;
  always #2 clk = ~clk;
  // outside driver always drives lines the block leaves alone
  assign pad = (~gpio_oe_n & gpio_out) | (gpio_oe_n & ext_val);
  assign miso_w = miso_oe_n ? ~miso : miso;
  assign irq_n = irq_oe_n ? 1'b1 : irq_out;
  sge_spi_host i_host (.clk(clk), .miso(miso_w), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  sge_top i_dut (.clk(clk), .reset_n(reset_n), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe_n(miso_oe_n), .gpio_in(pad), .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n), .gpio_pull_en(gpio_pull_en), .irq_out(irq_out), .irq_oe_n(irq_oe_n));
  task automatic summarize;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] rx;
    i_host.xfer({1'b0, a, d}, rx);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] rx;
    i_host.xfer({1'b1, a, 8'h00}, rx);
    `CHK(rx, exp)
  endtask : rd
  task automatic edge_chk(input logic v, input logic exp_n);
    @(negedge clk) ext_val[8] = v;
    repeat (10) @(negedge clk);
    `CHK(irq_n, exp_n)
  endtask : edge_chk
  task automatic t_reset;
    // 11 cycles: longer than the 40 ns minimum
    @(negedge clk) reset_n = 1'b0;
    repeat (11) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(gpio_oe_n, 16'hffff)
    `CHK(gpio_pull_en, 16'h0000)
    `CHK(irq_n, 1'b1)
    rd(7'(SGE_REG_DIR_HI), 8'hff);
    rd(7'(SGE_REG_OUT_LO), 8'h00);
  endtask : t_reset
  task automatic t_out;
    wr(7'(SGE_REG_DIR_LO), 8'h00);
    wr(7'(SGE_REG_OUT_LO), 8'ha5);
    wr(7'(SGE_REG_TRI_LO), 8'h0f);
    `CHK(gpio_oe_n, 16'hff0f)
    `CHK(gpio_out[7:0], 8'ha5)
    rd(7'(SGE_REG_TRI_LO), 8'h0f);
    wr(7'(SGE_REG_OUT_HI), 8'h3c);
    `CHK(gpio_out[15:8], 8'h3c)
    rd(7'(SGE_REG_OUT_HI), 8'h3c);
    wr(7'h30, 8'h55);
    rd(7'h30, 8'h00);
  endtask : t_out
  task automatic t_in;
    wr(7'(SGE_REG_PULL_HI), 8'h3c);
    wr(7'(SGE_REG_PULL_LO), 8'hff);
    `CHK(gpio_pull_en, 16'h3c00)
    wr(7'(SGE_REG_INV_HI), 8'hf0);
    ext_val = 16'h1200;
    repeat (6) @(negedge clk);
    rd(7'(SGE_REG_INPUT_HI), 8'he2);
    wr(7'(SGE_REG_INV_HI), 8'h00);
    rd(7'(SGE_REG_INPUT_HI), 8'h12);
    ext_val = 16'h0000;
  endtask : t_in
  task automatic t_irq;
    wr(7'(SGE_REG_IEN_HI), 8'h01);
    wr(7'(SGE_REG_RISE_HI), 8'h01);
    edge_chk(1'b1, 1'b0);
    rd(SGE_REG_PEND_HI, 8'h01);
    edge_chk(1'b0, 1'b1);
    wr(7'(SGE_REG_RISE_HI), 8'h00);
    wr(SGE_REG_FALL_HI, 8'h01);
    edge_chk(1'b1, 1'b1);
    edge_chk(1'b0, 1'b0);
    rd(7'(SGE_REG_INPUT_HI), 8'h00);
    `CHK(irq_n, 1'b1)
    wr(7'(SGE_REG_RISE_HI), 8'h01);
    edge_chk(1'b1, 1'b0);
    rd(7'(SGE_REG_INPUT_HI), 8'h01);
    edge_chk(1'b0, 1'b0);
    rd(7'(SGE_REG_INPUT_HI), 8'h00);
    wr(7'(SGE_REG_IEN_HI), 8'h00);
    edge_chk(1'b1, 1'b1);
  endtask : t_irq
  initial begin
    repeat (50000) @(posedge clk);
    mismatches++;
    summarize();
  end
  initial begin
    t_reset();
    t_out();
    t_in();
    t_irq();
    t_reset();
    summarize();
  end
endmodule : sge_top_bench
`default_nettype wire
